/* File: logic/psb_bank_top.sv */
// psb_bank_top: processor status register bank of one processor tile.
// assumes: the tile issues status reads and writes by register number,
// one per cycle; clk_in is the PLL output; ticks and straps are sync.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: tx data delay field, bits 25:18, resets zero
// RULE2: tx clock rises at divider, falls at half
// RULE3: software programs divider as ratio minus one
// RULE4: bit 8 enables rgmii peripheral ports
// RULE5: bit 5 divides only while threads paused
// RULE6: bit 4 enables low-power clock divider
// RULE7: bit 2 selects utmi, clear selects ulpi
// RULE8: bit 1 enables ulpi hardware support
// RULE9: boot status reports straps, read only
// RULE10: security lock bit refuses further writes
// RULE11: security bits block debug and jtag access
// RULE12: otp lock, redundancy and boot force bits
// RULE13: security register loads from otp word
// RULE14: oscillator enables start counters, reset zero
// RULE15: read counts ten cycles after stopping
// RULE16: oscillators run independent of core clock
// RULE17: counts are 16 bits, survive reset
// RULE18: four counts map cell, wire, cell, wire
// RULE19: memory size read only, low bits zero
// RULE20: debugger entry captures thread status
// RULE21: fast, paused and kernel status bits
// RULE22: interrupt, event sequence and enable bits
// RULE23: all registers reached by status number
// RULE24: reserved zero; debug fields need debug mode
// RULE25: writes to read-only registers do nothing
module psb_bank_top
    import psb_pkg::*;
#(
    parameter logic [31:0] MEM_BYTES = 32'h0004_0000 // plain default
) (
    input  wire logic                 clk_in,           // core/PLL clock
    input  wire logic                 rst_b_in,         // async reset
    input  wire logic                 ce_in,            // clock enable
    input  wire logic                 ps_sel_in,        // access request
    input  wire logic                 ps_wr_in,         // 1 write, 0 read
    input  wire logic [7:0]           ps_num_in,        // register number
    input  wire logic [31:0]          ps_wdata_in,      // write data
    output logic      [31:0]          ps_rdata_out,     // read data
    output logic                      ps_ack_out,       // access done
    input  wire logic                 debug_mode_in,    // in debug mode
    input  wire logic                 debug_entry_in,   // debugger entry
    input  wire logic [PSB_SSR_W-1:0] thread_status_in, // live status
    input  wire logic                 all_paused_in,    // threads paused
    input  wire logic                 otp_load_in,      // otp word valid
    input  wire logic [31:0]          otp_sec_word_in,  // otp security
    input  wire logic [7:0]           boot_proc_num_in, // processor no.
    input  wire logic                 boot_ovr_in,      // mode override
    input  wire logic [3:0]           boot_flags_in,    // c1off,nootp,ram,jtag
    input  wire logic [1:0]           boot_pll_mode_in, // pll mode straps
    input  wire logic [PSB_OSC_N-1:0] osc_tick_in,      // oscillator edges
    output logic                      core_osc_en_out,  // core osc run
    output logic                      peri_osc_en_out,  // periph osc run
    output logic [PSB_TXDLY_W-1:0]    rgmii_tx_dly_out, // tx data delay
    output logic                      rgmii_txc_out,    // tx clock
    output logic                      rgmii_en_out,     // rgmii ports on
    output logic                      lp_div_on_out,    // divider active
    output logic                      utmi_sel_out,     // 1 utmi, 0 ulpi
    output logic                      ulpi_hw_en_out,   // ulpi support on
    output logic                      gdbg_block_out,   // global debug off
    output logic                      jtag_cfg_block_out, // jtag cfg off
    output logic                      jtag_tap_block_out, // jtag tap off
    output logic                      otp_lock_all_out, // all sectors
    output logic [PSB_SEC_SECT_W-1:0] otp_sect_lock_out, // per sector
    output logic                      otp_red_en_out,   // redundancy
    output logic                      otp_boot_out      // boot from otp
);

    typedef struct packed {
        logic [31:0]            tile;
        logic [31:0]            boot;
        logic                   boot_taken;
        logic [31:0]            sec;
        logic [1:0]             osc;
        logic [PSB_SSR_W-1:0]   saved_thread_status;
        logic [31:0]            rdata;
        logic                   ack;
        logic [PSB_TXDIV_W-1:0] txc_cnt;
        logic                   txc;
        logic                   lp_on;
    } psb_state_t;

    psb_state_t q;
    psb_state_t d;

    psb_osc_if #(.N(PSB_OSC_N), .CW(PSB_OSC_CW)) osc ();

    psb_osc_counters #(
        .N  (PSB_OSC_N),
        .CW (PSB_OSC_CW)
    ) u_osc (
        .clk_in (clk_in),
        .ce_in  (ce_in),
        .osc    (osc.ctr)
    );

    assign osc.run  = q.osc;
    assign osc.tick = osc_tick_in; // RULE16

    // merges write data into a register under its writable mask
    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [31:0] mask);
        wmerge = (old_v & ~mask) | (new_v & mask);
    endfunction

    logic                   wr_hit;
    logic [PSB_TXDIV_W-1:0] txdiv;
    logic [7:0]             osc_idx;

    assign wr_hit  = ps_sel_in && ps_wr_in;
    assign txdiv   = q.tile[PSB_TXDIV_LSB +: PSB_TXDIV_W];
    assign osc_idx = ps_num_in - PSB_NUM_OSC_BASE;

    always_comb begin
        d     = q;
        d.ack = ps_sel_in; // RULE23

        // straps are caught on the first enabled edge after reset
        if (!q.boot_taken) begin
            d.boot_taken = 1'b1;
            d.boot = (32'(boot_proc_num_in) << PSB_BOOT_PROC_LSB)
                   | (32'(boot_ovr_in) << PSB_BOOT_OVR_BIT)
                   | (32'(boot_flags_in) << PSB_BOOT_FLAG_LSB)
                   | (32'(boot_pll_mode_in) << PSB_BOOT_PLL_LSB); // RULE9
        end

        // writes; read-only numbers fall through untouched
        if (wr_hit) begin
            case (ps_num_in)
                PSB_NUM_TILE_CTRL: begin
                    d.tile = wmerge(q.tile, ps_wdata_in,
                                    PSB_TILE_WMASK); // RULE24
                end
                PSB_NUM_SEC: begin
                    if (!q.sec[PSB_SEC_LOCK_BIT]) begin // RULE10
                        d.sec = wmerge(q.sec, ps_wdata_in, PSB_SEC_WMASK);
                    end
                end
                PSB_NUM_OSC_CTRL: begin
                    d.osc = ps_wdata_in[1:0]; // RULE14
                end
                PSB_NUM_DBG_SSR: begin
                    if (debug_mode_in) begin // RULE24
                        d.saved_thread_status = (q.saved_thread_status & ~PSB_SSR_WMASK)
                              | (ps_wdata_in[PSB_SSR_W-1:0]
                                 & PSB_SSR_WMASK); // RULE22
                    end
                end
                default: begin
                    d.tile = q.tile; // RULE25
                end
            endcase
        end

        // hardware loads win over a software write in the same cycle
        if (otp_load_in) begin
            d.sec = otp_sec_word_in & PSB_SEC_WMASK; // RULE13
        end
        if (debug_entry_in) begin
            d.saved_thread_status = thread_status_in & PSB_SSR_RMASK; // RULE20
        end

        // read data is the state before this cycle's write
        d.rdata = 32'h0000_0000;
        if (ps_sel_in && !ps_wr_in) begin
            case (ps_num_in)
                PSB_NUM_TILE_CTRL: d.rdata = q.tile & PSB_TILE_WMASK;
                PSB_NUM_BOOT:      d.rdata = q.boot;
                PSB_NUM_SEC:       d.rdata = q.sec & PSB_SEC_WMASK;
                PSB_NUM_OSC_CTRL:  d.rdata = 32'(q.osc);
                PSB_NUM_MEM_SIZE:  d.rdata = MEM_BYTES
                                           & ~32'h0000_0003; // RULE19
                PSB_NUM_DBG_SSR:   d.rdata = 32'(q.saved_thread_status & PSB_SSR_RMASK); // RULE21
                default: begin
                    // tile cell, tile wire, periph cell, periph wire
                    if (osc_idx < 8'(PSB_OSC_N)) begin // RULE18
                        d.rdata = 32'(osc.count[osc_idx[1:0]]); // RULE17
                    end
                end
            endcase
        end

        // tx clock: counter wraps after the programmed value
        if (q.tile[PSB_RGMII_EN_BIT]) begin
            d.txc_cnt = (q.txc_cnt >= txdiv) ? '0
                      : q.txc_cnt + PSB_TXDIV_W'(1);
            if (q.txc_cnt == txdiv) begin
                d.txc = 1'b1; // RULE2
            end else if (q.txc_cnt == (txdiv >> 1)) begin
                d.txc = 1'b0; // RULE2
            end
        end else begin
            d.txc_cnt = '0;
            d.txc     = 1'b0;
        end

        d.lp_on = q.tile[PSB_LP_EN_BIT]                              // RULE6
                && (!q.tile[PSB_LP_DYN_BIT] || all_paused_in); // RULE5
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q            <= '0;
            q.tile       <= PSB_TILE_RESET;
            q.sec        <= PSB_SEC_RESET;
            q.osc        <= PSB_OSC_RESET;
            q.saved_thread_status        <= PSB_SSR_RESET;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign ps_rdata_out       = q.rdata;
    assign ps_ack_out         = q.ack;
    assign core_osc_en_out    = q.osc[PSB_OSC_CORE_BIT];
    assign peri_osc_en_out    = q.osc[PSB_OSC_PERI_BIT];
    assign rgmii_tx_dly_out   = q.tile[PSB_TXDLY_LSB +: PSB_TXDLY_W]; // RULE1
    assign rgmii_txc_out      = q.txc;
    assign rgmii_en_out       = q.tile[PSB_RGMII_EN_BIT]; // RULE4
    assign lp_div_on_out      = q.lp_on;
    assign utmi_sel_out       = q.tile[PSB_UTMI_BIT]; // RULE7
    assign ulpi_hw_en_out     = q.tile[PSB_ULPI_HW_BIT]; // RULE8
    assign gdbg_block_out     = q.sec[PSB_SEC_GDBG_BIT]; // RULE11
    assign jtag_cfg_block_out = q.sec[PSB_SEC_JTAGCFG_BIT];
    assign jtag_tap_block_out = q.sec[PSB_SEC_JTAGTAP_BIT];
    assign otp_lock_all_out   = q.sec[PSB_SEC_OTPALL_BIT]; // RULE12
    assign otp_sect_lock_out  = q.sec[PSB_SEC_SECT_LSB +: PSB_SEC_SECT_W];
    assign otp_red_en_out     = q.sec[PSB_SEC_OTPRED_BIT];
    assign otp_boot_out       = q.sec[PSB_SEC_OTPBOOT_BIT];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in || !ce_in);

    AST_SEC_LOCKED: assert property ( // RULE10
        wr_hit && ps_num_in == PSB_NUM_SEC && q.sec[PSB_SEC_LOCK_BIT]
        && !otp_load_in |=> $stable(q.sec))
        else $error("locked security register took a write");

    AST_TXC_RISE: assert property ( // RULE2
        rgmii_en_out && q.txc_cnt == txdiv && $stable(q.tile)
        |=> rgmii_txc_out)
        else $error("tx clock did not rise at divider value");

    AST_TXC_FALL: assert property ( // RULE2
        rgmii_en_out && q.txc_cnt == (txdiv >> 1) && q.txc_cnt != txdiv
        |=> !rgmii_txc_out)
        else $error("tx clock did not fall at half value");

    AST_LP_MODE: assert property ( // RULE5
        ##1 lp_div_on_out == ($past(q.tile[PSB_LP_EN_BIT])
            && (!$past(q.tile[PSB_LP_DYN_BIT]) || $past(all_paused_in))))
        else $error("low-power divider state wrong");

    AST_BOOT_RO: assert property ( // RULE25
        wr_hit && ps_num_in == PSB_NUM_BOOT && q.boot_taken
        |=> $stable(q.boot))
        else $error("boot status changed on write");

    AST_SSR_CAPTURE: assert property ( // RULE20
        debug_entry_in |=> q.saved_thread_status == ($past(thread_status_in)
                                     & PSB_SSR_RMASK))
        else $error("saved status not captured on entry");

    AST_SSR_NODBG: assert property ( // RULE24
        wr_hit && ps_num_in == PSB_NUM_DBG_SSR && !debug_mode_in
        && !debug_entry_in |=> $stable(q.saved_thread_status))
        else $error("saved status written outside debug mode");

    AST_ACK: assert property ( // RULE23
        ps_sel_in |=> ps_ack_out ##1 !ps_ack_out || $past(ps_sel_in))
        else $error("access not acknowledged next cycle");

    AST_TXDLY: assert property ( // RULE1
        wr_hit && ps_num_in == PSB_NUM_TILE_CTRL
        |=> rgmii_tx_dly_out == $past(ps_wdata_in[PSB_TXDLY_LSB +:
                                                   PSB_TXDLY_W]))
        else $error("tx delay not taken from write");

    AST_RSVD_ZERO: assert property ( // RULE24
        ps_sel_in && !ps_wr_in && ps_num_in == PSB_NUM_TILE_CTRL
        |=> (ps_rdata_out & ~PSB_TILE_WMASK) == 32'h0000_0000)
        else $error("reserved bits read non-zero");

    AST_MEMSZ: assert property ( // RULE19
        ps_sel_in && !ps_wr_in && ps_num_in == PSB_NUM_MEM_SIZE
        |=> ps_rdata_out == (MEM_BYTES & ~32'h0000_0003))
        else $error("memory size read wrong");

    COV_SEC_LOCK: cover property (
        wr_hit && ps_num_in == PSB_NUM_SEC && q.sec[PSB_SEC_LOCK_BIT]);
    COV_TXC_TOGGLE: cover property (rgmii_txc_out ##1 !rgmii_txc_out);
    COV_DBG_ENTRY: cover property (debug_entry_in ##1 ps_sel_in);
    COV_OSC_READ: cover property (
        ps_sel_in && !ps_wr_in && ps_num_in == PSB_NUM_OSC_BASE);

endmodule
`default_nettype wire

/* File: logic/psb_pkg.sv */
// psb_pkg: register numbers, field positions, masks and reset values
// of the processor status register bank.
// assumes: 32-bit status words selected by an 8-bit register number.
package psb_pkg;

    // register numbers as used by the status read/write instructions
    localparam logic [7:0]  PSB_NUM_TILE_CTRL  = 8'h02;
    localparam logic [7:0]  PSB_NUM_BOOT       = 8'h03;
    localparam logic [7:0]  PSB_NUM_SEC        = 8'h05;
    localparam logic [7:0]  PSB_NUM_OSC_CTRL   = 8'h06;
    localparam logic [7:0]  PSB_NUM_OSC_BASE   = 8'h07;
    localparam logic [7:0]  PSB_NUM_MEM_SIZE   = 8'h0c;
    localparam logic [7:0]  PSB_NUM_DBG_SSR    = 8'h10;

    localparam int          PSB_OSC_N          = 4;
    localparam int          PSB_OSC_CW         = 16;

    // tile feature control
    localparam int          PSB_TXDLY_LSB      = 18;
    localparam int          PSB_TXDLY_W        = 8;
    localparam int          PSB_TXDIV_LSB      = 9;
    localparam int          PSB_TXDIV_W        = 9;
    localparam int          PSB_RGMII_EN_BIT   = 8;
    localparam int          PSB_LP_DYN_BIT     = 5;
    localparam int          PSB_LP_EN_BIT      = 4;
    localparam int          PSB_UTMI_BIT       = 2;
    localparam int          PSB_ULPI_HW_BIT    = 1;
    localparam logic [31:0] PSB_TILE_WMASK     = 32'h03ff_ff36;
    localparam logic [31:0] PSB_TILE_RESET     = 32'h0000_0000;

    // boot status
    localparam int          PSB_BOOT_PROC_LSB  = 16;
    localparam int          PSB_BOOT_OVR_BIT   = 8;
    localparam int          PSB_BOOT_FLAG_LSB  = 2;
    localparam int          PSB_BOOT_PLL_LSB   = 0;

    // security settings
    localparam int          PSB_SEC_LOCK_BIT   = 31;
    localparam int          PSB_SEC_GDBG_BIT   = 14;
    localparam int          PSB_SEC_OTPALL_BIT = 12;
    localparam int          PSB_SEC_SECT_LSB   = 8;
    localparam int          PSB_SEC_SECT_W     = 4;
    localparam int          PSB_SEC_OTPRED_BIT = 7;
    localparam int          PSB_SEC_OTPBOOT_BIT = 5;
    localparam int          PSB_SEC_JTAGCFG_BIT = 4;
    localparam int          PSB_SEC_JTAGTAP_BIT = 0;
    localparam logic [31:0] PSB_SEC_WMASK      = 32'h8000_5fb1;
    localparam logic [31:0] PSB_SEC_RESET      = 32'h0000_0000;

    // ring oscillator control
    localparam int          PSB_OSC_CORE_BIT   = 1;
    localparam int          PSB_OSC_PERI_BIT   = 0;
    localparam logic [1:0]  PSB_OSC_RESET      = 2'h0;

    // saved thread status
    localparam int          PSB_SSR_W          = 11;
    localparam int          PSB_SSR_ISSUE_BIT  = 8;
    localparam logic [10:0] PSB_SSR_RMASK      = 11'h7df;
    localparam logic [10:0] PSB_SSR_WMASK      = 11'h6df;
    localparam logic [10:0] PSB_SSR_RESET      = 11'h000;

endpackage

/* File: logic/psb_osc_if.sv */
// psb_osc_if: run controls, tick events and counts shared between the
// register bank and its ring oscillator counters.
// assumes: one clock domain; ticks already sampled to clk_in.
`timescale 1ns/100ps
`default_nettype none
interface psb_osc_if #(
    parameter int N  = 4,
    parameter int CW = 16
);
    logic [1:0]          run;    // core, peripheral oscillator enables
    logic [N-1:0]        tick;   // one tick per oscillator edge
    logic [N-1:0][CW-1:0] count; // free-running counts

    modport bank (output run, output tick, input count);
    modport ctr  (input run, input tick, output count);
endinterface
`default_nettype wire

/* File: logic/psb_osc_counters.sv */
// psb_osc_counters: four free-running ring oscillator counters.
// assumes: ticks arrive synchronous to clk_in; counters hold no reset.
`timescale 1ns/100ps
`default_nettype none
module psb_osc_counters
    import psb_pkg::*;
#(
    parameter int N  = PSB_OSC_N,
    parameter int CW = PSB_OSC_CW
) (
    input  wire logic clk_in,  // core clock
    input  wire logic ce_in,   // clock enable, freezes counts when low
    psb_osc_if.ctr    osc      // run, tick and count
);

    typedef struct packed {
        logic [N-1:0][CW-1:0] cnt;
    } psb_ctr_state_t;

    // power-up value only, so a count is never unknown; reset never clears it
    psb_ctr_state_t q = '0;
    psb_ctr_state_t d;

    // first half are tile oscillators, second half peripheral ones
    always_comb begin
        d = q;
        for (int i = 0; i < N; i++) begin
            if (osc.run[(i < N / 2) ? PSB_OSC_CORE_BIT : PSB_OSC_PERI_BIT]
                && osc.tick[i]) begin
                d.cnt[i] = q.cnt[i] + CW'(1); // RULE14
            end
        end
    end

    // no reset on purpose: a system reset keeps the count
    always_ff @(posedge clk_in) begin // RULE17
        if (ce_in) begin
            q <= d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_out
            assign osc.count[g] = q.cnt[g];
        end
    endgenerate

    AST_OSC_HOLD: assert property (@(posedge clk_in)
        !osc.run[PSB_OSC_CORE_BIT] |=> $stable(q.cnt[0])) // RULE14
        else $error("tile oscillator count moved while stopped");

endmodule
`default_nettype wire

/* File: tb/tb_psb_bank_top.sv */
// tb_psb_bank_top: self-checking bench for the processor status bank.
// assumes: psb_pkg compiled first; bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_psb_bank_top
    import psb_pkg::*;
;
    localparam logic [31:0] MEM = 32'h0002_0003; // low bits must read zero
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        sel = 1'b0, wr = 1'b0, dbg_mode = 1'b0, dbg_entry = 1'b0;
    logic [7:0]  num = 8'h00, b_proc;
    logic [31:0] wdata = 32'h0, rd, exp_v, otp_word = 32'h0;
    logic [10:0] tstat = 11'h0;
    logic        paused = 1'b0, otp_load = 1'b0, b_ovr;
    logic [3:0]  b_flags, tick = 4'h0;
    logic [1:0]  b_pll;
    logic [31:0] rd_o, cnt0 [4];
    logic        ack, c_en, p_en, txc, r_en, lp, utmi, ulpi, gdbg, jcfg, jtap;
    logic        lock_all, red, oboot;
    logic [7:0]  dly;
    logic [3:0]  sect;
    int          error_cnt = 0, n_checks = 0, cyc = 0, n;
    always #4 clk_in = ~clk_in;
    psb_bank_top #(.MEM_BYTES(MEM)) dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
        .ps_sel_in(sel), .ps_wr_in(wr), .ps_num_in(num),
        .ps_wdata_in(wdata), .ps_rdata_out(rd_o), .ps_ack_out(ack),
        .debug_mode_in(dbg_mode), .debug_entry_in(dbg_entry),
        .thread_status_in(tstat), .all_paused_in(paused),
        .otp_load_in(otp_load), .otp_sec_word_in(otp_word),
        .boot_proc_num_in(b_proc), .boot_ovr_in(b_ovr),
        .boot_flags_in(b_flags), .boot_pll_mode_in(b_pll),
        .osc_tick_in(tick), .core_osc_en_out(c_en), .peri_osc_en_out(p_en),
        .rgmii_tx_dly_out(dly), .rgmii_txc_out(txc), .rgmii_en_out(r_en),
        .lp_div_on_out(lp), .utmi_sel_out(utmi), .ulpi_hw_en_out(ulpi),
        .gdbg_block_out(gdbg), .jtag_cfg_block_out(jcfg),
        .jtag_tap_block_out(jtap), .otp_lock_all_out(lock_all),
        .otp_sect_lock_out(sect), .otp_red_en_out(red),
        .otp_boot_out(oboot));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one access per call; sel held until the taking edge, ack read just after that same edge
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        sel <= 1'b1;
        wr <= w;
        num <= a;
        wdata <= d;
        @(posedge clk_in);
        sel <= 1'b0;
        #1;
        `CHK(ack, 1'b1)
        rd = rd_o;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [31:0] boot_exp();
        return {8'h00, b_proc, 7'h00, b_ovr, 2'h0, b_flags, b_pll};
    endfunction
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'hbed2629b));
        {b_proc, b_ovr, b_flags, b_pll} = 15'($urandom);
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        // reset values, read-only places and an unmapped number
        chk_rd(PSB_NUM_TILE_CTRL, PSB_TILE_RESET);
        chk_rd(PSB_NUM_OSC_CTRL, 32'h0);
        chk_rd(PSB_NUM_BOOT, boot_exp());
        chk_rd(PSB_NUM_MEM_SIZE, MEM & ~32'h3);
        acc(1'b1, PSB_NUM_BOOT, ~boot_exp());
        acc(1'b1, PSB_NUM_MEM_SIZE, 32'hffff_ffff);
        chk_rd(PSB_NUM_BOOT, boot_exp());
        chk_rd(PSB_NUM_MEM_SIZE, MEM & ~32'h3);
        chk_rd(8'h04, 32'h0);
        $display("test reset_ro done");
        // tile control fields, random and all-ones
        for (int i = 0; i < 6; i++) begin
            exp_v = (i == 0) ? 32'hffff_ffff : $urandom;
            acc(1'b1, PSB_NUM_TILE_CTRL, exp_v);
            chk_rd(PSB_NUM_TILE_CTRL, exp_v & PSB_TILE_WMASK);
            `CHK(dly, exp_v[25:18])
            `CHK(r_en, exp_v[8])
            `CHK(utmi, exp_v[2])
            `CHK(ulpi, exp_v[1])
        end
        $display("test tile_ctrl done");
        // low-power divider, static and dynamic
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, PSB_NUM_TILE_CTRL, 32'h10 | (m[0] ? 32'h20 : 32'h0));
            paused <= m[1];
            wait_cyc(2);
            `CHK(lp, !m[0] || m[1])
        end
        acc(1'b1, PSB_NUM_TILE_CTRL, 32'h20);
        wait_cyc(2);
        `CHK(lp, 1'b0)
        $display("test low_power done");
        // tx clock period is divider field plus one
        for (int k = 0; k < 3; k++) begin
            exp_v = (k == 0) ? 32'd1 : (k == 1) ? 32'd3 : 32'd6;
            acc(1'b1, PSB_NUM_TILE_CTRL, (exp_v << 9) | 32'h100);
            n = 0;
            while (!(txc === 1'b0) && n < 40) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            while (txc !== 1'b1 && n < 40) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            n = 0;
            do begin
                @(posedge clk_in);
                #1;
                n++;
            end while (!(txc === 1'b0) && n < 40);
            while (txc !== 1'b1 && n < 40) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            `CHK(n, exp_v + 1)
        end
        $display("test tx_clock done");
        // security: otp load, write, then lock
        otp_word = $urandom & 32'h7fff_ffff;
        @(posedge clk_in);
        otp_load <= 1'b1;
        @(posedge clk_in);
        otp_load <= 1'b0;
        chk_rd(PSB_NUM_SEC, otp_word & PSB_SEC_WMASK);
        `CHK({gdbg, lock_all, sect}, {otp_word[14], otp_word[12:8]})
        `CHK({red, oboot, jcfg, jtap},
             {otp_word[7], otp_word[5:4], otp_word[0]})
        exp_v = ~otp_word & 32'h7fff_ffff;
        acc(1'b1, PSB_NUM_SEC, exp_v);
        chk_rd(PSB_NUM_SEC, exp_v & PSB_SEC_WMASK);
        acc(1'b1, PSB_NUM_SEC, 32'h8000_0000);
        acc(1'b1, PSB_NUM_SEC, 32'h0000_5fb1);
        chk_rd(PSB_NUM_SEC, 32'h8000_0000);
        `CHK({gdbg, jtap}, 2'b00)
        $display("test security done");
        // saved thread status: capture, refused and allowed writes
        tstat <= 11'($urandom);
        @(posedge clk_in);
        dbg_entry <= 1'b1;
        @(posedge clk_in);
        dbg_entry <= 1'b0;
        chk_rd(PSB_NUM_DBG_SSR, {21'h0, tstat & PSB_SSR_RMASK});
        exp_v = {21'h0, tstat & PSB_SSR_RMASK};
        acc(1'b1, PSB_NUM_DBG_SSR, ~exp_v);
        chk_rd(PSB_NUM_DBG_SSR, exp_v);
        dbg_mode <= 1'b1;
        acc(1'b1, PSB_NUM_DBG_SSR, ~exp_v);
        chk_rd(PSB_NUM_DBG_SSR,
               (~exp_v & PSB_SSR_WMASK) | (exp_v & 32'h100));
        dbg_mode <= 1'b0;
        $display("test saved_status done");
        // oscillator counts: core only, stop, settle, then reset survival
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, PSB_NUM_OSC_BASE + 8'(i), 32'h0);
            `CHK(rd[31:16], 16'h0000)
            cnt0[i] = rd;
        end
        acc(1'b1, PSB_NUM_OSC_CTRL, 32'hffff_fffe);
        chk_rd(PSB_NUM_OSC_CTRL, 32'h2);
        `CHK({c_en, p_en}, 2'b10)
        n = 3 + ($urandom % 20);
        repeat (n) begin
            @(posedge clk_in);
            tick <= 4'($urandom) | 4'h3;
            @(posedge clk_in);
            tick <= 4'h0;
        end
        acc(1'b1, PSB_NUM_OSC_CTRL, 32'h0);
        wait_cyc(10);
        for (int i = 0; i < 4; i++)
            chk_rd(PSB_NUM_OSC_BASE + 8'(i),
                   (cnt0[i] + (i < 2 ? n : 0)) & 32'hffff);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        wait_cyc(3);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 2; i++)
            chk_rd(PSB_NUM_OSC_BASE + 8'(i), (cnt0[i] + n) & 32'hffff);
        chk_rd(PSB_NUM_SEC, 32'h0);
        $display("test osc_counts done");
        close_out();
    end
endmodule
`default_nettype wire
